//--- rtl/ccs_defines.svh
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH
// ****************************************
// Register offsets and field positions
// ****************************************
`define CCS_TS_CTRL_OFS 8'h1b
`define CCS_CTRL0_OFS 8'h20
`define CCS_CTRL1_OFS 8'h21
`define CCS_STAT_OFS 8'h22
`define CCS_TS_CTRL_RST 8'h00
`define CCS_CTRL0_RST 8'h1f
`define CCS_CTRL1_RST 8'h00
// Control 0 bits
`define CCS_B_CHG_EN 0
`define CCS_B_TERM_EN 1
`define CCS_B_TMR_EN 2
`define CCS_B_2X_EN 3
`define CCS_B_PRE_EN 4
`define CCS_B_PROF_EN 5
`define CCS_B_TS_EN 6
`define CCS_B_CV_MASK 7
// Status codes
`define CCS_ST_IDLE 3'b000
`define CCS_ST_TRICKLE 3'b001
`define CCS_ST_PRE 3'b010
`define CCS_ST_CC 3'b011
`define CCS_ST_CV 3'b100
`define CCS_ST_TOPOFF 3'b110
`define CCS_ST_DONE 3'b111
// Timebase: one tick per second at 25 MHz
`define CCS_CLK_HZ 25000000
`define CCS_TICK_SEC 1
`define CCS_PRE_SEC 7200
`define CCS_HOUR_SEC 3600
`define CCS_TOP_UNIT_SEC 900
`define CCS_CV_UNIT_SEC 3600
`define CCS_ONE 32'h0000_0001
// Pin stages start with inhibit asserted and all zone bits clear
`define CCS_PIN_RST 6'h01
`endif

//--- rtl/ccs_pkg.sv
package ccs_pkg;
    // Temperature zones after qualification
    typedef enum logic [2:0] {
        ZN_NORMAL,
        ZN_COLD,
        ZN_COOL,
        ZN_WARM,
        ZN_HOT
    } ccs_zone_t;
    // Analog comparator results grouped together
    typedef struct packed {
        logic below_short;
        logic below_low;
        logic above_rechg;
        logic below_term_pin;
        logic below_term_reg;
        logic cv_reg;
        logic icl;
        logic vcl;
        logic fault;
    } ccs_cmp_t;
    // Derating outputs
    typedef struct packed {
        logic [1:0] cur_pct;
        logic volt_off;
        logic suspend;
    } ccs_derate_t;
endpackage

//--- rtl/ccs_top.sv
`timescale 1ns/1ns
`include "ccs_defines.svh"
// How it works
// - Terminate only above recharge, below termination current
// - Termination threshold is lower of pin, register
// - Termination: converter off, status 111, pulse
// - No termination while limiting or disabled
// - Optional top-off timer reports status 110
// - Top-off timer follows safety suspend and slowing
// - Top-off expiry sets 111 and pulses
// - Safety expiry sets fault, pulses; enable bit
// - Input limiting halves safety timer rate
// - Thermal derating halves rate; double-time bit gates
// - Charge faults hold safety count
// - Charge restart clears safety and CV timers
// - Two hour pre-charge timer below low threshold
// - CV timer programmable, zero disables, never slowed
// - CV timer pauses on faults or limiting
// - CV expiry pulses; the status change pulses even if masked
// - Charge only inside outer temperature window
// - Cool zone current select or suspend
// - Warm zone voltage offset or suspend
// - Warm zone current select or suspend
// - Profile off keeps window, no derating
// - Monitor off ignores thermistor, reports normal
// - Status codes; every transition pulses interrupt
module ccs_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Register port
    input wire logic REG_WE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Pins and comparators
    input wire logic CHG_INHIBIT_PIN,
    input wire logic [4:0] THERM_BELOW,
    input wire ccs_pkg::ccs_cmp_t CMP,
    // Outputs
    output logic CONV_ON,
    output logic [2:0] CHARGE_STATUS,
    output logic SAFETY_FAULT,
    output ccs_pkg::ccs_derate_t DERATE,
    output ccs_pkg::ccs_zone_t ZONE,
    output logic INT_PULSE
);
    // ****************************************
    // Timing constants
    // ****************************************
    // Clock cycles in one timer tick
    localparam int TICK_CYC = `CCS_CLK_HZ * `CCS_TICK_SEC;
    // Divider value at which the tick fires
    localparam logic [24:0] TICK_MAX = 25'(TICK_CYC - 1);
    // Pre-charge limit in whole ticks; this timer is never slowed
    localparam logic [17:0] PRE_TICKS = 18'(`CCS_PRE_SEC);

    // Registers
    logic [7:0] ts_ctrl_q, ts_ctrl_d; // Cool and warm zone derating control
    logic [7:0] ctrl0_q, ctrl0_d;     // Enable bits
    logic [7:0] ctrl1_q, ctrl1_d;     // Durations: safety[2:0] cv[5:3] topoff[7:6]

    // ****************************************
    // Pin synchroniser (inhibit, zone bits)
    // ****************************************
    // Capture stages and qualified value; bit 0 is the inhibit pin
    logic [5:0] s1_q, s2_q, s3_q, pin_q;
    // Next qualified value
    logic [5:0] pin_d;
    // A bit moves only once stages two and three agree
    always_comb begin
        pin_d = pin_q;
        for (int i = 0; i < 6; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                pin_d[i] = s3_q[i];
            end
        end
    end
    // Stages start at the inhibit level, so reset gives no false release
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s1_q <= `CCS_PIN_RST;
            s2_q <= `CCS_PIN_RST;
            s3_q <= `CCS_PIN_RST;
            pin_q <= `CCS_PIN_RST;
        end else begin
            s1_q <= {THERM_BELOW, CHG_INHIBIT_PIN};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
        end
    end

    // ****************************************
    // Register write and read
    // ****************************************
    // Next register values; the status address takes no write
    always_comb begin
        ts_ctrl_d = ts_ctrl_q;
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        if (REG_WE && REG_ADDR == `CCS_TS_CTRL_OFS) begin
            ts_ctrl_d = REG_WDATA;
        end else if (REG_WE && REG_ADDR == `CCS_CTRL0_OFS) begin
            ctrl0_d = REG_WDATA;
        end else if (REG_WE && REG_ADDR == `CCS_CTRL1_OFS) begin
            ctrl1_d = REG_WDATA;
        end
    end
    // Read mux; unmapped addresses read zero
    always_comb begin
        if (REG_ADDR == `CCS_TS_CTRL_OFS) begin
            REG_RDATA = ts_ctrl_q;
        end else if (REG_ADDR == `CCS_CTRL0_OFS) begin
            REG_RDATA = ctrl0_q;
        end else if (REG_ADDR == `CCS_CTRL1_OFS) begin
            REG_RDATA = ctrl1_q;
        end else if (REG_ADDR == `CCS_STAT_OFS) begin
            REG_RDATA = {1'b0, ZONE, SAFETY_FAULT, CHARGE_STATUS};
        end else begin
            REG_RDATA = 8'h00;
        end
    end
    // Register storage
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ts_ctrl_q <= `CCS_TS_CTRL_RST;
            ctrl0_q <= `CCS_CTRL0_RST;
            ctrl1_q <= `CCS_CTRL1_RST;
        end else begin
            ts_ctrl_q <= ts_ctrl_d;
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
        end
    end

    // ****************************************
    // Temperature zone and derating
    // ****************************************
    // THERM_BELOW[k]: sensed voltage below threshold k (T1..T5 falling)
    function automatic ccs_pkg::ccs_zone_t zone_of(input logic [4:0] b);
        if (!b[0]) return ccs_pkg::ZN_COLD;
        else if (!b[1]) return ccs_pkg::ZN_COOL;
        else if (!b[2]) return ccs_pkg::ZN_NORMAL;
        else if (!b[4]) return ccs_pkg::ZN_WARM;
        else return ccs_pkg::ZN_HOT;
    endfunction
    // Zone from the qualified pins, then the derating of that zone
    always_comb begin
        ZONE = ctrl0_q[`CCS_B_TS_EN] ? zone_of(pin_q[5:1]) : ccs_pkg::ZN_NORMAL;
        DERATE = '0;
        DERATE.cur_pct = 2'd3;
        if (ZONE == ccs_pkg::ZN_COLD || ZONE == ccs_pkg::ZN_HOT) begin
            DERATE.suspend = 1'b1;
        end else if (ctrl0_q[`CCS_B_PROF_EN] && ZONE == ccs_pkg::ZN_COOL) begin
            DERATE.cur_pct = ts_ctrl_q[1:0];
            DERATE.suspend = (ts_ctrl_q[1:0] == 2'd0);
        end else if (ctrl0_q[`CCS_B_PROF_EN] && ZONE == ccs_pkg::ZN_WARM) begin
            DERATE.volt_off = ts_ctrl_q[2];
            DERATE.cur_pct = ts_ctrl_q[4:3];
            DERATE.suspend = ts_ctrl_q[5] || ts_ctrl_q[4:3] == 2'd0;
        end
    end

    // ****************************************
    // Charge state, timers, interrupt
    // ****************************************
    // Run level last cycle and the half-rate phase
    logic en_q, en_d, tick_half_q, tick_half_d;
    // Timebase divider
    logic [24:0] div_q, div_d;
    // Safety, pre-charge, top-off and constant-voltage counts
    logic [17:0] safe_q, safe_d, pre_q, pre_d, top_q, top_d, cv_q, cv_d;
    // Charge status code
    logic [2:0] st_q, st_d;
    // Fault latch and interrupt pulse
    logic fault_q, fault_d, int_q, int_d;
    // Conditions that pace and gate the timers
    logic tick, run_en, halt, half, adv_full, adv_safe, limiting, term_ok;
    // Timer limits from the duration fields
    logic [17:0] safe_lim, cv_lim, top_lim;

    // One-cycle tick at the end of each divider pass
    assign tick = (div_q == TICK_MAX);
    assign limiting = CMP.icl | CMP.vcl;
    assign run_en = ctrl0_q[`CCS_B_CHG_EN] & ~pin_q[0];
    // Anything that suspends charging also freezes the timers
    assign halt = CMP.fault | DERATE.suspend | fault_q;
    assign half = ctrl0_q[`CCS_B_2X_EN] & (limiting | DERATE.cur_pct != 2'd3);
    // Whole-rate and paced advance enables
    assign adv_full = tick & ~halt;
    assign adv_safe = adv_full & (~half | tick_half_q);
    // Termination threshold: lower of pin-derived 10% and register setting
    assign term_ok = CMP.above_rechg & CMP.below_term_pin & CMP.below_term_reg
        & ~limiting & ctrl0_q[`CCS_B_TERM_EN];
    // Safety limit in half-seconds of count (its counter steps by 2 per paced tick); CV and top-off limits in whole ticks
    assign safe_lim = 18'((ctrl1_q[2:0] + 1) * `CCS_HOUR_SEC * 2);
    assign cv_lim = 18'(ctrl1_q[5:3] * `CCS_CV_UNIT_SEC);
    assign top_lim = 18'(ctrl1_q[7:6] * `CCS_TOP_UNIT_SEC);

    // Next charge state, timer counts and interrupt request
    always_comb begin
        div_d = tick ? 25'd0 : div_q + 25'd1;
        tick_half_d = tick ? ~tick_half_q : tick_half_q;
        en_d = run_en;
        safe_d = safe_q;
        pre_d = pre_q;
        top_d = top_q;
        cv_d = cv_q;
        st_d = st_q;
        fault_d = fault_q;
        int_d = 1'b0;
        // A fresh start clears every timer and the fault
        if (run_en && !en_q) begin
            safe_d = '0;
            cv_d = '0;
            pre_d = '0;
            top_d = '0;
            fault_d = 1'b0;
            st_d = `CCS_ST_IDLE;
        end else if (!run_en) begin
            st_d = `CCS_ST_IDLE;
        end else if (st_q == `CCS_ST_DONE) begin
            // Stay done until the battery falls below recharge
            if (!CMP.above_rechg) st_d = `CCS_ST_IDLE;
        end else if (st_q == `CCS_ST_TOPOFF) begin
            // Top-off keeps the safety timer's pace and pauses
            if (adv_safe) top_d = top_q + 18'd1;
            if (top_q >= top_lim) st_d = `CCS_ST_DONE;
        end else if (halt) begin
            // Suspended: hold phase and counts
            st_d = st_q;
        end else if (st_q == `CCS_ST_IDLE) begin
            // Start once nothing suspends charging
            st_d = `CCS_ST_CC;
        end else begin
            // Phase from the battery band; limiting leaves CV
            if (ctrl0_q[`CCS_B_PRE_EN] && CMP.below_short) st_d = `CCS_ST_TRICKLE;
            else if (ctrl0_q[`CCS_B_PRE_EN] && CMP.below_low) st_d = `CCS_ST_PRE;
            else if (CMP.cv_reg && !limiting) st_d = `CCS_ST_CV;
            else st_d = `CCS_ST_CC;
            // Safety count steps by two per paced tick
            if (ctrl0_q[`CCS_B_TMR_EN] && adv_safe) safe_d = safe_q + 18'd2;
            if (ctrl0_q[`CCS_B_TMR_EN] && safe_q >= safe_lim) begin
                fault_d = 1'b1;
                int_d = 1'b1;
            end
            // Pre-charge time only runs below the low threshold
            if (ctrl0_q[`CCS_B_PRE_EN] && CMP.below_low && adv_full) begin
                pre_d = pre_q + 18'd1;
                if (pre_q >= PRE_TICKS) fault_d = 1'b1;
            end
            // CV time only runs while regulating in CV
            if (st_q == `CCS_ST_CV && CMP.cv_reg && !limiting && cv_lim != '0) begin
                if (adv_full) cv_d = cv_q + 18'd1;
                if (cv_q >= cv_lim) begin
                    st_d = `CCS_ST_DONE;
                    // Keep a safety pulse raised in this same cycle
                    int_d = int_d | ~ctrl0_q[`CCS_B_CV_MASK];
                end
            end
            // Termination overrides every other phase choice
            if (term_ok) begin
                st_d = (top_lim != '0) ? `CCS_ST_TOPOFF : `CCS_ST_DONE;
            end
        end
        // Every status change raises the pulse; events merge
        if (st_d != st_q) int_d = 1'b1;
    end
    // Charge state storage
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            div_q <= '0;
            tick_half_q <= 1'b0;
            en_q <= 1'b0;
            safe_q <= '0;
            pre_q <= '0;
            top_q <= '0;
            cv_q <= '0;
            st_q <= `CCS_ST_IDLE;
            fault_q <= 1'b0;
            int_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_half_q <= tick_half_d;
            en_q <= en_d;
            safe_q <= safe_d;
            pre_q <= pre_d;
            top_q <= top_d;
            cv_q <= cv_d;
            st_q <= st_d;
            fault_q <= fault_d;
            int_q <= int_d;
        end
    end
    // Status, fault and pulse straight from the state flip-flops; CONV_ON also decodes run_en and halt
    assign CHARGE_STATUS = st_q;
    assign SAFETY_FAULT = fault_q;
    assign INT_PULSE = int_q;
    assign CONV_ON = run_en & ~halt & (st_q != `CCS_ST_IDLE) & (st_q != `CCS_ST_DONE);
endmodule

//--- sim/ccs_plant.sv
`timescale 1ns/1ns
// ****************************************
// Battery and thermistor model
// ****************************************
module ccs_plant (
    // Conditions chosen by the bench
    input logic [2:0] temp,
    input logic [1:0] batt,
    input logic [1:0] tap,
    input logic [1:0] lim,
    input logic flt,
    // Comparator outputs
    output logic [4:0] therm_below,
    output ccs_pkg::ccs_cmp_t cmp
);
    // Thermistor ladder: a warmer pack passes more thresholds
    always_comb begin
        case (temp)
            3'd0: therm_below = 5'h00;
            3'd1: therm_below = 5'h01;
            3'd2: therm_below = 5'h03;
            3'd3: therm_below = 5'h07;
            default: therm_below = 5'h1f;
        endcase
    end
    // Battery voltage band and taper current
    always_comb begin
        cmp.below_short = (batt == 2'd0);
        cmp.below_low = (batt < 2'd2);
        cmp.above_rechg = (batt == 2'd3);
        cmp.cv_reg = (batt == 2'd3);
        cmp.below_term_pin = tap[0];
        cmp.below_term_reg = tap[1];
        cmp.icl = lim[0];
        cmp.vcl = lim[1];
        cmp.fault = flt;
    end
endmodule

//--- sim/ccs_top_chk.sv
`timescale 1ns/1ns
`include "ccs_defines.svh"
// ****************************************
// Port checker
// ****************************************
module ccs_chk (
    // Clock and reset
    input logic CLK,
    input logic RST_B,
    // Register port
    input logic REG_WE,
    input logic [7:0] REG_ADDR,
    input logic [7:0] REG_WDATA,
    input logic [7:0] REG_RDATA,
    // Pins
    input logic CHG_INHIBIT_PIN,
    input logic [4:0] THERM_BELOW,
    input ccs_pkg::ccs_cmp_t CMP,
    // Outputs
    input logic CONV_ON,
    input logic [2:0] CHARGE_STATUS,
    input logic SAFETY_FAULT,
    input ccs_pkg::ccs_derate_t DERATE,
    input ccs_pkg::ccs_zone_t ZONE,
    input logic INT_PULSE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    property p_int_on_change;
        $changed(CHARGE_STATUS) |-> INT_PULSE;
    endproperty
    a_int_on_change: assert property (p_int_on_change) else $error("no pulse on status");
    property p_code_legal;
        CHARGE_STATUS != 3'b101;
    endproperty
    a_code_legal: assert property (p_code_legal) else $error("reserved status code");
    property p_done_off;
        CHARGE_STATUS == `CCS_ST_DONE |-> !CONV_ON;
    endproperty
    a_done_off: assert property (p_done_off) else $error("converter on when done");
    property p_term_cause;
        CHARGE_STATUS inside {`CCS_ST_DONE, `CCS_ST_TOPOFF}
            && $past(CHARGE_STATUS) inside {`CCS_ST_CC, `CCS_ST_CV}
            |-> $past(!CMP.icl && !CMP.vcl)
                && ($past(CMP.above_rechg && CMP.below_term_pin && CMP.below_term_reg)
                || (CHARGE_STATUS == `CCS_ST_DONE && $past(CHARGE_STATUS) == `CCS_ST_CV
                && $past(CMP.cv_reg)));
    endproperty
    a_term_cause: assert property (p_term_cause) else $error("bad termination");
    property p_mon_off;
        REG_ADDR == `CCS_CTRL0_OFS && !REG_RDATA[6] |-> ZONE == ccs_pkg::ZN_NORMAL;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("zone with monitor off");
    property p_window;
        ZONE inside {ccs_pkg::ZN_COLD, ccs_pkg::ZN_HOT} |-> !CONV_ON;
    endproperty
    a_window: assert property (p_window) else $error("charging outside window");
    property p_fault_off;
        SAFETY_FAULT || CMP.fault |-> !CONV_ON;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("charging in fault");
    property p_inhibit;
        CHG_INHIBIT_PIN [*6] |-> !CONV_ON;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("charging while inhibited");
    property p_prof_off;
        REG_ADDR == `CCS_CTRL0_OFS && !REG_RDATA[5] && ZONE inside {ccs_pkg::ZN_COOL,
            ccs_pkg::ZN_WARM} |-> DERATE.cur_pct == 2'd3 && !DERATE.volt_off;
    endproperty
    a_prof_off: assert property (p_prof_off) else $error("derating with profile off");
    c_cc: cover property (CHARGE_STATUS == `CCS_ST_CC);
    c_done: cover property (CHARGE_STATUS == `CCS_ST_DONE);
    c_cool: cover property (ZONE == ccs_pkg::ZN_COOL);
endmodule
bind ccs_top ccs_chk u_chk (.CLK, .RST_B, .REG_WE, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .CHG_INHIBIT_PIN, .THERM_BELOW, .CMP, .CONV_ON, .CHARGE_STATUS, .SAFETY_FAULT,
    .DERATE, .ZONE, .INT_PULSE);

//--- sim/tb_ccs_top.sv
`timescale 1ns/1ns
`include "ccs_defines.svh"
// ****************************************
// Testbench
// ****************************************
module tb_ccs_top;
    logic clk = 1'b0;
    logic rst_b;
    logic reg_we;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic inhibit;
    logic [4:0] therm;
    ccs_pkg::ccs_cmp_t cmp;
    logic conv_on;
    logic safety_fault;
    logic [2:0] charge_status;
    ccs_pkg::ccs_derate_t derate;
    ccs_pkg::ccs_zone_t zone;
    logic int_pulse;
    logic [2:0] temp;
    logic [1:0] batt;
    logic [1:0] tap;
    logic [1:0] lim;
    logic flt;
    int bad_count;
    int samples_checked;
    int int_count = 0;
    int n;
    // Battery bands and the status each one gives; temperatures and the zone each one gives
    logic [1:0] bt [4] = '{2'd1, 2'd0, 2'd2, 2'd3};
    logic [2:0] st [4] = '{`CCS_ST_PRE, `CCS_ST_TRICKLE, `CCS_ST_CC, `CCS_ST_CV};
    logic [2:0] tz [4] = '{3'd0, 3'd4, 3'd1, 3'd3};
    ccs_pkg::ccs_zone_t zz [4] = '{ccs_pkg::ZN_COLD, ccs_pkg::ZN_HOT, ccs_pkg::ZN_COOL,
        ccs_pkg::ZN_WARM};
    always #20 clk = ~clk;
    // Interrupt pulse counter
    // Counted mid-cycle, away from the edge that launches the pulse
    always @(negedge clk) if (int_pulse === 1'b1) int_count++;
    ccs_top u_dut (.CLK(clk), .RST_B(rst_b), .REG_WE(reg_we), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CHG_INHIBIT_PIN(inhibit),
        .THERM_BELOW(therm), .CMP(cmp), .CONV_ON(conv_on), .CHARGE_STATUS(charge_status),
        .SAFETY_FAULT(safety_fault), .DERATE(derate), .ZONE(zone), .INT_PULSE(int_pulse));
    ccs_plant u_plant (.temp(temp), .batt(batt), .tap(tap), .lim(lim), .flt(flt),
        .therm_below(therm), .cmp(cmp));
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(posedge clk);
        #2 reg_we = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        cyc(1);
        reg_addr = a;
        cyc(1);
        chk("rdata", e, reg_rdata);
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task wait_st(input logic [2:0] e);
        for (int i = 0; i < 20 && charge_status !== e; i++) cyc(1);
        chk("status", 8'(e), 8'(charge_status));
    endtask
    task give_verdict();
        if (bad_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        bad_count = 0;
        samples_checked = 0;
        {rst_b, reg_we, reg_addr, reg_wdata, inhibit, flt} = {2'b00, 16'h0000, 2'b10};
        {temp, batt, tap, lim} = {3'd2, 2'd2, 2'd0, 2'd0};
        repeat (6) @(posedge clk);
        #2 rst_b = 1'b1;
        rd(`CCS_TS_CTRL_OFS, `CCS_TS_CTRL_RST);
        rd(`CCS_CTRL0_OFS, `CCS_CTRL0_RST);
        rd(`CCS_CTRL1_OFS, `CCS_CTRL1_RST);
        rd(`CCS_STAT_OFS, 8'h00);
        rd(8'h55, 8'h00);
        wr(`CCS_STAT_OFS, 8'hff);
        rd(`CCS_STAT_OFS, 8'h00);
        wr(`CCS_TS_CTRL_OFS, 8'h2a);
        rd(`CCS_TS_CTRL_OFS, 8'h2a);
        temp = 3'd0;
        cyc(6);
        chk("zone", 8'(ccs_pkg::ZN_NORMAL), 8'(zone));
        temp = 3'd2;
        inhibit = 1'b0;
        n = int_count;
        wait_st(`CCS_ST_CC);
        chk("conv", 8'h01, 8'(conv_on));
        // Each battery band gives its own status; a pulse is checked for every band except the last (CV)
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            chk("int", 8'h01, 8'(int_count > n));
            n = int_count;
            batt = bt[i];
            wait_st(st[i]);
        end
        tap = 2'b01;
        cyc(10);
        chk("status", 8'(`CCS_ST_CV), 8'(charge_status));
        tap = 2'b11;
        lim = 2'b11;
        cyc(10);
        // Limiting blocks termination and pulls the charger out of CV
        chk("status", 8'(`CCS_ST_CC), 8'(charge_status));
        wr(`CCS_CTRL0_OFS, 8'h1d);
        lim = 2'b00;
        cyc(10);
        chk("status", 8'(`CCS_ST_CV), 8'(charge_status));
        n = int_count;
        wr(`CCS_CTRL0_OFS, 8'h1f);
        wait_st(`CCS_ST_DONE);
        chk("conv", 8'h00, 8'(conv_on));
        cyc(1);
        chk("int", 8'h01, 8'(int_count > n));
        {tap, batt} = {2'd0, 2'd2};
        wr(`CCS_CTRL0_OFS, 8'h7f);
        inhibit = 1'b1;
        wait_st(`CCS_ST_IDLE);
        inhibit = 1'b0;
        wait_st(`CCS_ST_CC);
        // Zones, and no charging at the outer edges
        for (int i = 0; i < 4; i++) begin
            temp = tz[i];
            cyc(6);
            chk("zone", 8'(zz[i]), 8'(zone));
            if (i < 2) chk("conv", 8'h00, 8'(conv_on));
        end
        temp = 3'd1;
        wr(`CCS_CTRL0_OFS, 8'h5f);
        cyc(4);
        chk("zone", 8'(ccs_pkg::ZN_COOL), 8'(zone));
        chk("cur_pct", 8'h03, 8'(derate.cur_pct));
        chk("volt_off", 8'h00, 8'(derate.volt_off));
        wr(`CCS_CTRL0_OFS, 8'h7f);
        wr(`CCS_TS_CTRL_OFS, 8'h20);
        temp = 3'd3;
        cyc(6);
        chk("suspend", 8'h01, 8'(derate.suspend));
        temp = 3'd2;
        cyc(8);
        chk("conv", 8'h01, 8'(conv_on));
        flt = 1'b1;
        cyc(6);
        chk("conv", 8'h00, 8'(conv_on));
        chk("fault", 8'h00, 8'(safety_fault));
        give_verdict();
    end
endmodule
